// *** rtl/sacs_top.sv ***
// Successive-approximation converter control sequencer with Avalon-MM slave
//
// Notes on behaviour
// - ladder bit 0 attaches only during conversion
// - time codes give 39 to 1248 cycles
// - control two bits 7:6 read undefined; this design reads them as zero
// - standby resets control two, ignores writes
// - status holds result, done, busy bits
// - upper result read clears done flag
// - busy set at start, cleared at end
// - soft mode start bit begins one conversion
// - end writes results, sets done, fires irq
// - start bit self-clears once conversion begins
// - repeat mode chains conversions back to back
// - mode 00 aborts, partial result discarded
// - new start clears done, keeps old result
// - standby aborts, resets controls, loses results
// - no automatic resume after standby
// - standby disconnects the reference ladder
// - upper 8 bits upper, low 2 in status
// - mode codes off, soft, reserved, repeat
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`include "sacs_defines.svh"

module sacs_top
  import sacs_pkg::*;
(
  input  wire logic        clk,             // 25 MHz main clock
  input  wire logic        rst,             // Async reset, active high
  input  wire logic [7:0]  address,         // Avalon word address
  input  wire logic        read,            // Avalon read
  input  wire logic        write,           // Avalon write
  input  wire logic [31:0] writedata,       // Avalon write data
  input  wire logic [3:0]  byteenable,      // Avalon byte enables
  output logic      [31:0] readdata,        // Avalon read data
  output logic             waitrequest,     // Avalon wait
  input  wire logic        standby_mode,    // Stop, slow or sleep active
  input  wire logic        comparator_out,  // High: input above DAC level
  output logic      [9:0]  dac_code,        // Trial code to ladder DAC
  output logic             sample_hold,     // High while sampling
  output logic      [3:0]  channel_select,  // Analog channel to convert
  output logic             analog_input_gate, // High disables inputs
  output logic             ladder_connect,  // Reference ladder attached
  output logic             conv_done_irq    // One-cycle completion pulse
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [7:0]  ctl_one_q;
  logic [7:0]  ctl_two_q;
  logic [7:0]  result_upper_q;
  logic [1:0]  result_low_q;
  logic        done_q;
  logic        ack_q;
  logic [31:0] readdata_q;
  logic        irq_q;
  sacs_state_t state_q;
  logic [3:0]  phase_q;
  logic [11:0] step_cnt_q;
  logic [9:0]  sar_q;
  logic [9:0]  trial_bit_q;
  logic [2:0]  time_shift_q;

  logic        req;
  logic        access;
  logic        wr_lane0;
  logic        wr_ctl_one;
  logic        wr_ctl_two;
  logic        rd_upper;
  logic        mode_ok;
  logic        busy;
  logic        start_conv;
  logic        abort_conv;
  logic        step_end;
  logic        conv_end;
  logic [2:0]  time_shift;
  logic [11:0] step_len;
  logic [9:0]  sar_next;
  sacs_mode_t  mode;
  logic        restart;
  logic        hit_ctl_one;
  logic        hit_ctl_two;
  logic        hit_status;
  logic        hit_upper;
  logic [7:0]  ctl_two_view;
  logic [7:0]  status_byte;

  // --------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------
  // Every access waits one cycle so read data come from a flip-flop
  assign req         = read | write;
  assign waitrequest = req & ~ack_q;
  assign access      = req & ack_q;
  assign wr_lane0    = write & access & byteenable[0] & ~standby_mode;
  assign wr_ctl_one  = wr_lane0 & hit_ctl_one;
  assign wr_ctl_two  = wr_lane0 & hit_ctl_two;
  assign rd_upper    = read & access & hit_upper;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // One hit per mapped register; unmapped indices hit nothing
  always_comb begin
    hit_ctl_one = 1'b0;
    hit_ctl_two = 1'b0;
    hit_status  = 1'b0;
    hit_upper   = 1'b0;
    if (address == `SACS_IDX_CTL_ONE) begin
      hit_ctl_one = 1'b1;
    end else if (address == `SACS_IDX_CTL_TWO) begin
      hit_ctl_two = 1'b1;
    end else if (address == `SACS_IDX_STATUS_LOW) begin
      hit_status = 1'b1;
    end else if (address == `SACS_IDX_RESULT_UPPER) begin
      hit_upper = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      if (hit_ctl_one) begin
        readdata_q <= {24'h00_0000, ctl_one_q};
      end else if (hit_ctl_two) begin
        readdata_q <= {24'h00_0000, ctl_two_view};
      end else if (hit_status) begin
        readdata_q <= {24'h00_0000, status_byte};
      end else if (hit_upper) begin
        readdata_q <= {24'h00_0000, result_upper_q};
      end else begin
        readdata_q <= 32'h0000_0000;
      end
    end
  end

  // Undefined and unstable bits read as zero
  assign ctl_two_view = {2'h0, ctl_two_q[5:0]};
  assign status_byte  = {result_low_q, done_q, busy, 4'h0};
  assign readdata     = readdata_q;

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  assign mode    = sacs_mode_t'(ctl_one_q[`SACS_C1_MODE_HI:`SACS_C1_MODE_LO]);
  assign mode_ok = (mode == SACS_SOFT) || (mode == SACS_REPEAT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_one_q <= `SACS_CTL_ONE_RST;
    end else if (standby_mode) begin
      ctl_one_q <= `SACS_CTL_ONE_RST;
    end else if (wr_ctl_one) begin
      ctl_one_q <= writedata[7:0];
    end else if (start_conv) begin
      ctl_one_q[`SACS_C1_START_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_two_q <= `SACS_CTL_TWO_RST;
    end else if (standby_mode) begin
      ctl_two_q <= `SACS_CTL_TWO_RST;
    end else if (wr_ctl_two) begin
      ctl_two_q <= writedata[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Conversion length
  // --------------------------------------------------------------------
  // Thirteen equal steps: three for sampling, ten for the bits
  always_comb begin
    case (ctl_two_q[`SACS_C2_TIME_HI:`SACS_C2_TIME_LO])
      3'b000:  time_shift = 3'h0;
      3'b010:  time_shift = 3'h1;
      3'b011:  time_shift = 3'h2;
      3'b100:  time_shift = 3'h3;
      3'b101:  time_shift = 3'h4;
      default: time_shift = 3'h5; // Reserved codes run longest
    endcase
  end

  // Length is held from start, so a rewrite of control two while busy
  // neither stretches nor cuts the conversion under way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      time_shift_q <= 3'h0;
    end else if (!busy || restart) begin
      time_shift_q <= time_shift;
    end
  end

  assign step_len = `SACS_STEP_BASE << time_shift_q;

  // --------------------------------------------------------------------
  // Sequencer control
  // --------------------------------------------------------------------
  // Off or reserved mode, or standby, stops a conversion at once
  assign busy       = (state_q != SACS_IDLE);
  assign start_conv = !standby_mode && !busy && mode_ok &&
                      ctl_one_q[`SACS_C1_START_BIT];
  assign abort_conv = busy && (standby_mode || !mode_ok);
  assign step_end   = busy && (step_cnt_q == step_len - 12'h001);
  assign conv_end   = step_end && (phase_q == `SACS_LAST_PHASE) &&
                      !abort_conv;
  assign restart    = conv_end && (mode == SACS_REPEAT);

  // Repeat mode re-enters sampling on the completing edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SACS_IDLE;
    end else begin
      case (state_q)
        SACS_IDLE: begin
          if (start_conv) begin
            state_q <= SACS_SAMPLE;
          end
        end
        SACS_SAMPLE: begin
          if (abort_conv) begin
            state_q <= SACS_IDLE;
          end else if (step_end &&
                       phase_q == `SACS_SAMPLE_PHASES - 4'h1) begin
            state_q <= SACS_APPROX;
          end
        end
        SACS_APPROX: begin
          if (abort_conv) begin
            state_q <= SACS_IDLE;
          end else if (conv_end) begin
            if (mode == SACS_REPEAT) begin
              state_q <= SACS_SAMPLE;
            end else begin
              state_q <= SACS_IDLE;
            end
          end
        end
        default: state_q <= SACS_IDLE;
      endcase
    end
  end

  // Cycle counter within one step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_cnt_q <= 12'h000;
    end else if (!busy || abort_conv || step_end) begin
      step_cnt_q <= 12'h000;
    end else begin
      step_cnt_q <= step_cnt_q + 12'h001;
    end
  end

  // Step counter: three sample steps, then one step per result bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 4'h0;
    end else if (!busy || abort_conv) begin
      phase_q <= 4'h0;
    end else if (step_end) begin
      phase_q <= (phase_q == `SACS_LAST_PHASE) ? 4'h0 : phase_q + 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // Successive approximation
  // --------------------------------------------------------------------
  // Keep the trial bit when the input stays above the DAC level
  genvar bit_idx;
  for (bit_idx = 0; bit_idx < `SACS_RESULT_BITS; bit_idx++) begin : g_keep
    assign sar_next[bit_idx] = sar_q[bit_idx] &
                               (comparator_out | ~trial_bit_q[bit_idx]);
  end

  // Trial code: the next lower bit is tried once a step is judged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sar_q <= 10'h000;
    end else if (state_q != SACS_APPROX || abort_conv) begin
      sar_q <= 10'h200;
    end else if (step_end) begin
      sar_q <= sar_next | (trial_bit_q >> 1);
    end
  end

  // One-hot pointer to the bit under test, MSB first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trial_bit_q <= 10'h000;
    end else if (state_q != SACS_APPROX || abort_conv) begin
      trial_bit_q <= 10'h200;
    end else if (step_end) begin
      trial_bit_q <= trial_bit_q >> 1;
    end
  end

  assign dac_code = sar_q;

  // --------------------------------------------------------------------
  // Results, done flag, interrupt
  // --------------------------------------------------------------------
  // Standby wipes results; an aborted conversion stores nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_upper_q <= 8'h00;
      result_low_q   <= 2'h0;
    end else if (standby_mode) begin
      result_upper_q <= 8'h00;
      result_low_q   <= 2'h0;
    end else if (conv_end) begin
      result_upper_q <= sar_next[9:2];
      result_low_q   <= sar_next[1:0];
    end
  end

  // Completion wins over a clearing read in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (standby_mode) begin
      done_q <= 1'b0;
    end else if (conv_end) begin
      done_q <= 1'b1;
    end else if (rd_upper || start_conv) begin
      done_q <= 1'b0;
    end
  end

  // Pulse for one cycle after each completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= conv_end;
    end
  end

  assign conv_done_irq = irq_q;

  // --------------------------------------------------------------------
  // Analog side controls
  // --------------------------------------------------------------------
  assign sample_hold       = (state_q == SACS_SAMPLE);
  assign channel_select    = ctl_one_q[`SACS_C1_CH_HI:0];
  assign analog_input_gate = ctl_one_q[`SACS_C1_GATE_BIT];
  // Ladder follows the conversion unless held on, never in standby
  assign ladder_connect    = !standby_mode &&
                             (ctl_two_q[`SACS_C2_LADDER_BIT] || busy);

endmodule : sacs_top

// *** rtl/sacs_defines.svh ***
// Register map, field positions, reset values and timing counts
`ifndef SACS_DEFINES_SVH
`define SACS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SACS_IDX_CTL_ONE      8'h1C
`define SACS_IDX_CTL_TWO      8'h1D
`define SACS_IDX_STATUS_LOW   8'h1E
`define SACS_IDX_RESULT_UPPER 8'h1F

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SACS_C1_START_BIT     7
`define SACS_C1_MODE_HI       6
`define SACS_C1_MODE_LO       5
`define SACS_C1_GATE_BIT      4
`define SACS_C1_CH_HI         3
`define SACS_C2_LADDER_BIT    5
`define SACS_C2_TIME_HI       3
`define SACS_C2_TIME_LO       1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SACS_CTL_ONE_RST      8'h00
`define SACS_CTL_TWO_RST      8'h00

// ----------------------------------------------------------------------
// Timing: shortest conversion in main oscillator cycles
// ----------------------------------------------------------------------
`define SACS_CONV_BASE_CYC    39
`define SACS_SAMPLE_PHASES    4'h3
`define SACS_LAST_PHASE       4'hC
`define SACS_STEP_BASE        12'h003
`define SACS_RESULT_BITS      10

`endif

// *** rtl/sacs_pkg.sv ***
// Types shared by the converter sequencer
package sacs_pkg;

  typedef enum logic [1:0] {
    SACS_OFF    = 2'b00,
    SACS_SOFT   = 2'b01,
    SACS_RSVD   = 2'b10,
    SACS_REPEAT = 2'b11
  } sacs_mode_t;

  // Gray code along idle -> sample -> approximate
  typedef enum logic [1:0] {
    SACS_IDLE   = 2'b00,
    SACS_SAMPLE = 2'b01,
    SACS_APPROX = 2'b11
  } sacs_state_t;

endpackage : sacs_pkg

// *** testbench/sacs_properties.sv ***
// Port-level checks for the converter sequencer
`timescale 1ns/10ps
module sacs_checker (
  input wire logic        clk,            // clock
  input wire logic        rst,            // reset
  input wire logic [7:0]  address,        // word index
  input wire logic        read,           // read
  input wire logic        write,          // write
  input wire logic [31:0] writedata,      // write data
  input wire logic [3:0]  byteenable,     // lanes
  input wire logic [31:0] readdata,       // read data
  input wire logic        waitrequest,    // wait
  input wire logic        standby_mode,   // standby
  input wire logic        sample_hold,    // sampling
  input wire logic [3:0]  channel_select, // channel
  input wire logic        ladder_connect, // ladder
  input wire logic        conv_done_irq   // done pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ladder_off; standby_mode |-> !ladder_connect; endproperty
  a_ladder_off: assert property (p_ladder_off)
    else $error("ladder attached in standby");
  property p_ladder_conv;
    sample_hold && !standby_mode |-> ladder_connect;
  endproperty
  a_ladder_conv: assert property (p_ladder_conv)
    else $error("ladder detached while converting");
  property p_one_wait; (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer late");
  property p_irq_pulse; conv_done_irq |=> !conv_done_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("done pulse too long");
  property p_irq_quiet;
    standby_mode && $past(standby_mode) |-> !conv_done_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("done pulse in standby");
  property p_abort; standby_mode |=> !sample_hold; endproperty
  a_abort: assert property (p_abort)
    else $error("sampling in standby");
  property p_chan;
    write && !waitrequest && address == 8'h1C && byteenable[0]
      && !standby_mode |=> channel_select == $past(writedata[3:0]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel not taken");
  property p_status;
    read && !waitrequest && address == 8'h1E
      |-> readdata[3:0] == 4'h0 && readdata[31:8] == 24'h0;
  endproperty
  a_status: assert property (p_status)
    else $error("status spare bits set");
  property p_ctl_two;
    read && !waitrequest && address == 8'h1D |-> readdata[7:6] == 2'h0;
  endproperty
  a_ctl_two: assert property (p_ctl_two)
    else $error("control two top bits set");
endmodule : sacs_checker
bind sacs_top sacs_checker i_chk (.clk, .rst, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .standby_mode,
  .sample_hold, .channel_select, .ladder_connect, .conv_done_irq);

// *** testbench/sacs_analog_model.sv ***
// Analog front end: sample-hold, ladder and comparator
`timescale 1ns/10ps
module sacs_analog_model (
  input  wire logic       clk,            // clock
  input  wire logic [9:0] level,          // input level
  input  wire logic [9:0] dac_code,       // trial code
  input  wire logic       sample_hold,    // sampling
  input  wire logic       ladder_connect, // ladder
  output logic            comparator_out  // compare result
);
  logic [9:0] held_q;
  logic       noise_q = 1'b0;
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      held_q <= level;
    end
    noise_q <= ~noise_q;
  end
  // Ideal settling: even the shortest time code is long enough
  // No reference without the ladder: output wanders
  assign comparator_out = ladder_connect ? held_q >= dac_code : noise_q;
endmodule : sacs_analog_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "sacs_defines.svh"
module tb_top;
  localparam logic [7:0] C1 = `SACS_IDX_CTL_ONE;
  localparam logic [7:0] C2 = `SACS_IDX_CTL_TWO;
  localparam logic [7:0] ST = `SACS_IDX_STATUS_LOW;
  localparam logic [7:0] UP = `SACS_IDX_RESULT_UPPER;
  logic        clk, rst, read, write, waitrequest, standby_mode;
  logic        comparator_out, sample_hold, analog_input_gate;
  logic        ladder_connect, conv_done_irq;
  logic [7:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, channel_select;
  logic [9:0]  dac_code, level;
  int          fails, checks;
  sacs_top i_dut (.clk, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .standby_mode, .comparator_out,
    .dac_code, .sample_hold, .channel_select, .analog_input_gate,
    .ladder_connect, .conv_done_irq);
  sacs_analog_model i_ana (.clk, .level, .dac_code, .sample_hold,
    .ladder_connect, .comparator_out);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [31:0] q);
    @(posedge clk);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= w;
    read      <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, q, e);
  endtask : rdchk
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (conv_done_irq !== 1'b1 && n < 3000);
  endtask : wait_irq
  task automatic t_regs;
    rdchk("ctl1", C1, 32'h0);
    rdchk("status", ST, 32'h0);
    rdchk("upper", UP, 32'h0);
    wr(C1, 8'h13);
    @(posedge clk);
    chk("gate", analog_input_gate, 32'h1);
    rdchk("ctl1 rw", C1, 32'h13);
    wr(C2, 8'hD0);
    rdchk("ctl2", C2, 32'h10);
    wr(8'h20, 8'hFF);
    rdchk("unmapped", 8'h20, 32'h0);
  endtask : t_regs
  task automatic t_soft;
    int n;
    level <= 10'h2B6;
    wr(C2, 8'h10);
    wr(C1, 8'hA5);
    rdchk("start", C1, 32'h25);
    rdchk("busy", ST, 32'h10);
    chk("ladder", ladder_connect, 32'h1);
    chk("chan", channel_select, 32'h5);
    wait_irq(n);
    rdchk("done", ST, 32'hA0);
    rdchk("result", UP, 32'hAD);
    rdchk("cleared", ST, 32'h80);
    chk("ladder idle", ladder_connect, 32'h0);
  endtask : t_soft
  task automatic t_times;
    logic [7:0] cd[7] = '{8'h10, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E};
    int len[7] = '{39, 78, 156, 312, 624, 1248, 1248};
    int n, n0;
    for (int k = 0; k < 7; k++) begin
      wr(C2, cd[k]);
      wr(C1, 8'hA0);
      wait_irq(n);
      if (k == 0) n0 = n;
      chk("length", n - n0, len[k] - 39);
    end
  endtask : t_times
  task automatic t_restart;
    int n;
    wr(C2, 8'h10);
    level <= 10'h0C3;
    wr(C1, 8'hA0);
    rdchk("old low", ST, 32'h90);
    rdchk("old up", UP, 32'hAD);
    wait_irq(n);
    rdchk("new up", UP, 32'h30);
  endtask : t_restart
  task automatic t_repeat;
    int n;
    level <= 10'h155;
    wr(C1, 8'hE0);
    wait_irq(n);
    wait_irq(n);
    chk("period", n, 39);
    rdchk("rpt status", ST, 32'h70);
    rdchk("rpt up", UP, 32'h55);
    level <= 10'h3FF;
    wr(C1, 8'h00);
    wait_irq(n);
    chk("stopped", n, 3000);
    rdchk("kept low", ST, 32'h40);
    rdchk("kept up", UP, 32'h55);
  endtask : t_repeat
  task automatic t_standby;
    int n;
    wr(C2, 8'h30);
    @(posedge clk);
    chk("ladder on", ladder_connect, 32'h1);
    level <= 10'h200;
    wr(C1, 8'hA3);
    repeat (5) @(posedge clk);
    standby_mode <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ladder off", ladder_connect, 32'h0);
    wr(C1, 8'hA3);
    wr(C2, 8'h30);
    @(posedge clk);
    standby_mode <= 1'b0;
    rdchk("sb ctl1", C1, 32'h0);
    rdchk("sb ctl2", C2, 32'h0);
    rdchk("sb status", ST, 32'h0);
    rdchk("sb up", UP, 32'h0);
    wait_irq(n);
    chk("no resume", n, 3000);
  endtask : t_standby
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    standby_mode = 1'b0;
    level = 10'h000;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_soft;
    t_times;
    t_restart;
    t_repeat;
    t_standby;
    report_and_stop;
  end
endmodule : tb_top
